//--- rtl/ebr_ctrl.sv
// wait-state and bus-ownership control of the external bus
`timescale 1ns/1ps
module ebr_ctrl #(
  parameter int ACCESS_MAX = 32
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire ebr_pkg::ebr_cfg_t cfg_i,
  input wire logic cycle_req_i,
  input wire logic bus_need_i,
  input wire logic ready_pin_i,
  input wire logic hold_n_i,
  output logic cycle_done_o,
  output logic bus_owned_o,
  output ebr_pkg::ebr_ctrl_pins_t ctrl_o,
  output logic bus_release_ack_n_o,
  output logic bus_regain_request_n_o,
  output logic bus_reference_clock_out_o
);

  if (ACCESS_MAX < 1 || ACCESS_MAX > int'(ebr_pkg::ACC_LEN_MAX)) begin : g_bad_access_max
    $error("ACCESS_MAX out of range");
  end

  // zero length is served as the shortest phase
  function automatic logic [ebr_pkg::ACC_LEN_W-1:0] eff_len(input logic [ebr_pkg::ACC_LEN_W-1:0] len);
    begin
      if (len < ebr_pkg::ACC_LEN_MIN) begin
        eff_len = ebr_pkg::ACC_LEN_MIN;
      end else if (len > ebr_pkg::ACC_LEN_W'(ACCESS_MAX)) begin
        eff_len = ebr_pkg::ACC_LEN_W'(ACCESS_MAX);
      end else begin
        eff_len = len;
      end
    end
  endfunction

  // one bus clock unit is one system clock, forwarded as reference clock
  assign bus_reference_clock_out_o = clock_i;

  // pin synchronisers
  logic [ebr_pkg::RDY_SYNC_DEPTH-1:0] rdy_sync;
  logic [ebr_pkg::RDY_SYNC_DEPTH-1:0] next_rdy_sync;
  logic [ebr_pkg::HOLD_SYNC_DEPTH-1:0] hold_sync;
  logic [ebr_pkg::HOLD_SYNC_DEPTH-1:0] next_hold_sync;

  always_comb begin
    next_rdy_sync = {rdy_sync[ebr_pkg::RDY_SYNC_DEPTH-2:0], ready_pin_i};
    next_hold_sync = {hold_sync[ebr_pkg::HOLD_SYNC_DEPTH-2:0], hold_n_i};
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdy_sync <= '0;
      hold_sync <= '1;
    end else begin
      rdy_sync <= next_rdy_sync;
      hold_sync <= next_hold_sync;
    end
  end

  logic rdy_seen;
  logic rdy_act;
  logic hold_req;
  // async mode takes the extra stage
  assign rdy_seen = cfg_i.ready_async ? rdy_sync[ebr_pkg::RDY_SYNC_DEPTH-1]
                                      : rdy_sync[ebr_pkg::RDY_SYNC_DEPTH-2];
  assign rdy_act = (rdy_seen == cfg_i.ready_active_high);
  assign hold_req = cfg_i.arb_enable && !hold_sync[ebr_pkg::HOLD_SYNC_DEPTH-1];

  // bus cycle and arbitration state
  ebr_pkg::ebr_state_t state;
  ebr_pkg::ebr_state_t next_state;
  logic [ebr_pkg::ACC_LEN_W-1:0] cnt;
  logic [ebr_pkg::ACC_LEN_W-1:0] next_cnt;
  logic ale;
  logic next_ale;
  logic ack_n;
  logic next_ack_n;
  logic req_n;
  logic next_req_n;
  logic start;
  logic sample;

  assign start = (state == ebr_pkg::ST_IDLE) && cycle_req_i && !hold_req;
  // ready is looked at only from the last clock of the programmed access phase on
  assign sample = ((state == ebr_pkg::ST_ACCESS) && (cnt == ebr_pkg::ACC_LEN_MIN))
                  || (state == ebr_pkg::ST_WAIT);

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    unique case (state)
      ebr_pkg::ST_IDLE: begin
        // a new cycle only starts from idle, so a hold waits for the running one
        if (hold_req) begin
          next_state = ebr_pkg::ST_REL;
        end else if (cycle_req_i) begin
          next_state = ebr_pkg::ST_ACCESS;
          next_cnt = eff_len(cfg_i.access_phase_length);
        end
      end
      ebr_pkg::ST_ACCESS: begin
        if (!sample) begin
          next_cnt = cnt - ebr_pkg::ACC_LEN_MIN;
        end else if (rdy_act) begin
          next_state = ebr_pkg::ST_IDLE;
        end else begin
          next_state = ebr_pkg::ST_WAIT;
        end
      end
      ebr_pkg::ST_WAIT: begin
        // no timeout: waits as long as ready stays inactive
        if (rdy_act) begin
          next_state = ebr_pkg::ST_IDLE;
        end
      end
      ebr_pkg::ST_REL: begin
        next_state = ebr_pkg::ST_HELD;
      end
      ebr_pkg::ST_HELD: begin
        // leaves only on hold withdrawal, with or without own request
        if (!hold_req) begin
          next_state = ebr_pkg::ST_REGAIN;
        end
      end
      ebr_pkg::ST_REGAIN: begin
        next_state = ebr_pkg::ST_IDLE;
      end
      default: begin
        next_state = ebr_pkg::ST_IDLE;
      end
    endcase
    next_ale = start;
    next_ack_n = (next_state != ebr_pkg::ST_HELD);
    // request only once release is already acknowledged
    next_req_n = !((state == ebr_pkg::ST_HELD) && !ack_n && hold_req && bus_need_i);
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ebr_pkg::ST_IDLE;
      cnt <= '0;
      ale <= 1'b0;
      ack_n <= 1'b1;
      req_n <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      ale <= next_ale;
      ack_n <= next_ack_n;
      req_n <= next_req_n;
    end
  end

  assign cycle_done_o = sample && rdy_act;
  assign bus_owned_o = (state != ebr_pkg::ST_HELD);
  assign bus_release_ack_n_o = ack_n;
  assign bus_regain_request_n_o = req_n;
  // strobes inactive but driven in release and regain, floated while held
  assign ctrl_o = '{
    cmd_n: !((state == ebr_pkg::ST_ACCESS) || (state == ebr_pkg::ST_WAIT)),
    ctrl_oe_n: (state == ebr_pkg::ST_HELD),
    ale: ale
  };

  // checks
  logic [7:0] strobe_len;
  logic [7:0] next_strobe_len;
  always_comb begin
    next_strobe_len = ctrl_o.cmd_n ? 8'h00 : strobe_len + 8'h01;
  end
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      strobe_len <= 8'h00;
    end else begin
      strobe_len <= next_strobe_len;
    end
  end

  sequence s_release;
    (state == ebr_pkg::ST_REL) && ctrl_o.cmd_n && !ctrl_o.ctrl_oe_n && !ctrl_o.ale;
  endsequence
  sequence s_floated;
    ctrl_o.ctrl_oe_n && !ctrl_o.ale && !bus_release_ack_n_o;
  endsequence

  a_access_min_len: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    cycle_done_o |-> (strobe_len + 8'h01) >= {2'h0, eff_len(cfg_i.access_phase_length)})
    else $error("cycle ended before programmed access phase");

  a_wait_not_ready: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (sample && !rdy_act) |=> (state == ebr_pkg::ST_WAIT) && !ctrl_o.cmd_n)
    else $error("no wait state on inactive ready");

  a_end_on_ready: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (sample && rdy_act) |=> ctrl_o.cmd_n && (state == ebr_pkg::ST_IDLE))
    else $error("cycle not ended on active ready");

  a_no_timeout: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ((state == ebr_pkg::ST_WAIT) && !rdy_act) |=> (state == ebr_pkg::ST_WAIT) && !ctrl_o.cmd_n)
    else $error("wait ended without ready");

  a_sync_ready_path: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ((state == ebr_pkg::ST_WAIT) && !cfg_i.ready_async && ($past(ready_pin_i, 2) == cfg_i.ready_active_high))
    |=> state == ebr_pkg::ST_IDLE)
    else $error("sync ready not seen after two stages");

  a_async_ready_path: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ((state == ebr_pkg::ST_WAIT) && cfg_i.ready_async && ($past(ready_pin_i, 3) != cfg_i.ready_active_high))
    |=> state == ebr_pkg::ST_WAIT)
    else $error("async ready skipped its extra stage");

  a_hold_enabled: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state == ebr_pkg::ST_REL) |-> $past(cfg_i.arb_enable) && $past(state == ebr_pkg::ST_IDLE))
    else $error("release without enable or during a cycle");

  a_release_order: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state == ebr_pkg::ST_REL) |-> s_release ##1 s_floated)
    else $error("release sequence out of order");

  a_regain_order: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state == ebr_pkg::ST_REGAIN) |-> ctrl_o.cmd_n && !ctrl_o.ctrl_oe_n && !ctrl_o.ale
    ##1 (state == ebr_pkg::ST_IDLE) && ctrl_o.cmd_n)
    else $error("regain sequence out of order");

  a_req_after_ack: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !bus_regain_request_n_o |-> !bus_release_ack_n_o && $past(!bus_release_ack_n_o))
    else $error("bus request before acknowledge");

  a_regain_on_hold: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ((state == ebr_pkg::ST_HELD) && !hold_req) |=> (state == ebr_pkg::ST_REGAIN) && bus_release_ack_n_o)
    else $error("regain not started on hold withdrawal");

endmodule

//--- rtl/ebr_pkg.sv
// constants, types and states of the external bus ready and arbitration block
// What this block does
// - ready input may stretch the access phase; otherwise it lasts its programmed length
// - a configuration bit selects active-high or active-low ready
// - synchronous ready is timed to the reference clock and gives the shortest cycle
// - asynchronous ready passes one more synchroniser stage, so it is seen one clock later than synchronous ready
// - ready sampled inactive inserts one wait state and samples again
// - ready sampled active ends the running bus cycle
// - sample points differ by mode; ready ignored during programmed access wait states
// - hold requests are honoured only when arbitration is enabled
// - a running cycle completes before hold acknowledge and bus release
// - on release strobes are driven inactive, then floated high, address latch low
// - on regain strobes are driven inactive before any cycle, address latch low
// - bus request output stays inactive until bus release has been acknowledged
// - regain starts only when hold request goes away, whatever the bus request did
// - hold may be withdrawn without a bus request and the bus is regained normally
package ebr_pkg;
  localparam int ACC_LEN_W = 6;
  localparam logic [5:0] ACC_LEN_MIN = 6'h01;
  localparam logic [5:0] ACC_LEN_MAX = 6'h20;
  localparam int RDY_SYNC_DEPTH = 3;
  localparam int HOLD_SYNC_DEPTH = 2;

  typedef struct packed {
    logic ready_active_high;
    logic ready_async;
    logic arb_enable;
    logic [ACC_LEN_W-1:0] access_phase_length;
  } ebr_cfg_t;

  typedef struct packed {
    logic cmd_n;
    logic ctrl_oe_n;
    logic ale;
  } ebr_ctrl_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ACCESS = 3'h1,
    ST_WAIT = 3'h3,
    ST_REL = 3'h2,
    ST_HELD = 3'h6,
    ST_REGAIN = 3'h4
  } ebr_state_t;
endpackage

//--- verif/ebr_partner.sv
// ready responder on the far side of the external bus
`timescale 1ns/1ps
module ebr_partner (
  input wire logic clock_i,
  input wire logic cmd_n_i,
  input wire logic active_high_i,
  input int delay_i,
  output logic ready_o
);
  int cnt = 0;
  logic act = 1'b0;
  // answers delay_i clocks into the strobe, drops once it rises
  always @(negedge clock_i) begin
    if (cmd_n_i) begin
      cnt <= 0;
      act <= 1'b0;
    end else begin
      cnt <= cnt + 1;
      act <= (cnt >= delay_i);
    end
  end
  assign ready_o = act ? active_high_i : ~active_high_i;
endmodule

//--- verif/ext_bus_ready_and_arbitration_bench.sv
// self-checking bench of the external bus ready and arbitration block
`timescale 1ns/1ps
module ext_bus_ready_and_arbitration_bench;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  ebr_pkg::ebr_cfg_t cfg = '0;
  logic req = 1'b0;
  logic need = 1'b0;
  logic hold_n = 1'b1;
  logic rdy;
  logic done;
  logic owned;
  logic ack_n;
  logic req_n;
  logic refclk;
  ebr_pkg::ebr_ctrl_pins_t ctrl;
  int dly = 0;
  int errors = 0;
  int comparisons = 0;
  int len;
  int l1;
  logic [31:0] r;
  logic [31:0] seed = 32'h128167bf;
  always #20 clock_i = ~clock_i;
  ebr_ctrl dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .cfg_i(cfg), .cycle_req_i(req), .bus_need_i(need),
    .ready_pin_i(rdy), .hold_n_i(hold_n), .cycle_done_o(done), .bus_owned_o(owned), .ctrl_o(ctrl),
    .bus_release_ack_n_o(ack_n), .bus_regain_request_n_o(req_n), .bus_reference_clock_out_o(refclk));
  ebr_partner far (.clock_i(refclk), .cmd_n_i(ctrl.cmd_n), .active_high_i(cfg.ready_active_high),
    .delay_i(dly), .ready_o(rdy));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int exp_len(input int l);
    return (l < 1) ? 1 : (l > 32) ? 32 : l;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // one bus cycle, len counts clocks from request to done
  task automatic cyc(input int l, input int d, input logic as, input logic pol);
    cfg.access_phase_length = l[5:0];
    cfg.ready_async = as;
    cfg.ready_active_high = pol;
    dly = d;
    repeat (4) @(negedge clock_i);
    req = 1'b1;
    len = 0;
    do begin
      @(negedge clock_i);
      len++;
      chk(ack_n, 1'b1);
    end while (done !== 1'b1 && len < 200);
    req = 1'b0;
    // config holds until the ending edge has passed
    @(negedge clock_i);
  endtask
  task automatic wait_ack(input logic v);
    int n = 0;
    while (ack_n !== v && n < 8) begin
      @(negedge clock_i);
      n++;
    end
    chk(ack_n, v);
  endtask
  always @(negedge clock_i) begin
    if (req_n === 1'b0) begin
      chk(ack_n, 1'b0);
    end
  end
  initial begin
    #160000;
    errors++;
    summarize();
  end
  initial begin
    repeat (2) @(negedge clock_i);
    rst_b_i = 1'b1;
    #30;
    chk(refclk, 1'b1);
    #20;
    chk(refclk, 1'b0);
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      l1 = 6 + int'(r[4:0]) % 27;
      cyc(l1, 0, r[8], r[9]);
      chk(len, exp_len(l1));
    end
    cyc(40, 0, 1'b0, 1'b1);
    chk(len, exp_len(40));
    cyc(1, 6, 1'b0, 1'b1);
    l1 = len;
    cyc(1, 7, 1'b0, 1'b1);
    chk(len, l1 + 1);
    cyc(1, 6, 1'b1, 1'b0);
    chk(len, l1 + 1);
    cyc(1, 6, 1'b0, 1'b0);
    chk(len, l1);
    cyc(0, 6, 1'b0, 1'b1);
    chk(len, l1);
    cyc(1, 40, 1'b0, 1'b1);
    chk(len, l1 + 34);
    hold_n = 1'b0;
    repeat (8) @(negedge clock_i);
    chk({ack_n, owned}, 2'b11);
    hold_n = 1'b1;
    // let the synchronised hold settle before enabling arbitration
    repeat (3) @(negedge clock_i);
    cfg.arb_enable = 1'b1;
    need = 1'b1;
    fork
      cyc(1, 10, 1'b0, 1'b1);
      begin
        repeat (7) @(negedge clock_i);
        hold_n = 1'b0;
      end
    join
    wait_ack(1'b0);
    chk({ctrl, owned}, 4'b1100);
    repeat (12) @(negedge clock_i);
    chk({ack_n, req_n}, 2'b00);
    hold_n = 1'b1;
    wait_ack(1'b1);
    chk({ctrl, owned}, 4'b1001);
    cyc(6, 0, 1'b0, 1'b1);
    chk(len, 6);
    need = 1'b0;
    hold_n = 1'b0;
    wait_ack(1'b0);
    repeat (4) @(negedge clock_i);
    chk(req_n, 1'b1);
    hold_n = 1'b1;
    wait_ack(1'b1);
    cyc(6, 0, 1'b0, 1'b1);
    chk(len, 6);
    summarize();
  end
endmodule
